// [hdl/blit_cfg_pkg.sv]
// Constants and types for the block-transfer engine configuration registers
package blit_cfg_pkg;
  localparam logic [23:0] MONO_SRC_CTRL_OFFSET = 24'h40000C;
  localparam logic [23:0] BLIT_CTRL_OFFSET = 24'h400010;
  // Writable bit masks; every other bit reads zero, except blit control bit 31, which reads the busy status
  localparam logic [31:0] MONO_SRC_CTRL_MASK = 32'h0F3F3F3F;
  localparam logic [31:0] BLIT_CTRL_MASK = 32'h03FFF7FF;
  localparam logic [31:0] MONO_SRC_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] BLIT_CTRL_RESET = 32'h00000000;
  localparam int BUSY_BIT = 31;
  localparam int SRC_EXP_SEL_BIT = 27;
  localparam int ALIGN_LSB = 24;
  localparam int DISCARD_LSB = 16;
  localparam int RCLIP_LSB = 8;
  localparam int LCLIP_LSB = 0;
  localparam int DEPTH_LSB = 24;
  localparam int DEPTH_SEL_BIT = 23;
  localparam int VALIGN_LSB = 20;
  localparam int SOLID_PAT_BIT = 19;
  localparam int PAT_MONO_BIT = 18;
  localparam int SRC_MONO_BIT = 12;
  localparam int CFG_DEPTH_LSB = 4;
  localparam int DEST_ALIGN_W = 3;

  typedef enum logic [1:0] {
    DEPTH_8 = 2'h0,
    DEPTH_16 = 2'h1,
    DEPTH_24 = 2'h2,
    DEPTH_RSVD = 2'h3
  } depth_t;

  typedef enum logic [2:0] {
    ALIGN_RSVD0 = 3'h0,
    ALIGN_BIT = 3'h1,
    ALIGN_BYTE = 3'h2,
    ALIGN_WORD = 3'h3,
    ALIGN_DWORD = 3'h4,
    ALIGN_QWORD = 3'h5,
    ALIGN_RSVD6 = 3'h6,
    ALIGN_RSVD7 = 3'h7
  } align_t;
endpackage : blit_cfg_pkg

// [hdl/blit_color_expand.sv]
// Expansion color masking by color depth
`timescale 1ns/10ps
module blit_color_expand (
  input wire logic [1:0] depth,
  input wire logic [23:0] bg_in,
  input wire logic [23:0] fg_in,
  output logic [23:0] bg_out,
  output logic [23:0] fg_out
);
  // Keep only the bytes that the active depth uses
  wire [23:0] depth_mask;
  assign depth_mask = (depth == blit_cfg_pkg::DEPTH_24) ? 24'hFFFFFF :
                      (depth == blit_cfg_pkg::DEPTH_16) ? 24'h00FFFF : 24'h0000FF;
  assign bg_out = bg_in & depth_mask;
  assign fg_out = fg_in & depth_mask;
endmodule : blit_color_expand

// [hdl/blit_mono_source_and_control.sv]
// Monochrome source control and blit control registers with derived engine settings
`timescale 1ns/10ps
module blit_mono_source_and_control (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [23:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [3:0] REG_BE,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_ACK,
  input wire logic ENGINE_BUSY,
  input wire logic [7:0] CFG_REG,
  input wire logic [2:0] DEST_ADDR_LOW,
  input wire logic [23:0] SHARED_BG_COLOR,
  input wire logic [23:0] SHARED_FG_COLOR,
  input wire logic [23:0] SRC_BG_COLOR,
  input wire logic [23:0] SRC_FG_COLOR,
  output logic [1:0] ACTIVE_DEPTH,
  output logic [1:0] BYTES_PER_PIXEL,
  output logic DEPTH_RESERVED,
  output logic [23:0] SRC_EXP_BG,
  output logic [23:0] SRC_EXP_FG,
  output logic [23:0] PAT_EXP_BG,
  output logic [23:0] PAT_EXP_FG,
  output logic MONO_SRC_ACTIVE,
  output logic [2:0] SRC_ALIGN,
  output logic SRC_ALIGN_RESERVED,
  output logic [5:0] SRC_DISCARD,
  output logic [5:0] SRC_RCLIP,
  output logic [5:0] SRC_LCLIP,
  output logic [2:0] PAT_ROW,
  output logic [2:0] PAT_HALIGN,
  output logic PAT_READ_EN,
  output logic PAT_FORCE_BG
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage and bus decode
  logic [31:0] mono_src_ctrl;
  logic [31:0] blit_ctrl;
  logic [31:0] next_mono_src_ctrl;
  logic [31:0] next_blit_ctrl;
  logic busy_sync1;
  logic busy_sync2;
  logic [7:0] cfg_sync1;
  logic [7:0] cfg_sync2;
  logic [2:0] dest_sync1;
  logic [2:0] dest_sync2;

  // Expand byte enables into a bit mask; 16-bit accesses use two lanes
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Merge write data into a register through lanes and writable bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] lanes, input logic [31:0] wmask);
    merge = ((old & ~lanes) | (wd & lanes)) & wmask;
  endfunction : merge

  wire hit_src;
  wire hit_ctl;
  wire [31:0] lanes;
  assign hit_src = (REG_ADDR == blit_cfg_pkg::MONO_SRC_CTRL_OFFSET);
  assign hit_ctl = (REG_ADDR == blit_cfg_pkg::BLIT_CTRL_OFFSET);
  assign lanes = lane_mask(REG_BE);

  // Next register values; masks keep reserved bits and the busy bit at zero
  assign next_mono_src_ctrl = (REG_WR && hit_src) ?
    merge(mono_src_ctrl, REG_WDATA, lanes, blit_cfg_pkg::MONO_SRC_CTRL_MASK) : mono_src_ctrl;
  assign next_blit_ctrl = (REG_WR && hit_ctl) ?
    merge(blit_ctrl, REG_WDATA, lanes, blit_cfg_pkg::BLIT_CTRL_MASK) : blit_ctrl;

  // Register update
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mono_src_ctrl <= blit_cfg_pkg::MONO_SRC_CTRL_RESET;
      blit_ctrl <= blit_cfg_pkg::BLIT_CTRL_RESET;
    end else begin
      mono_src_ctrl <= next_mono_src_ctrl;
      blit_ctrl <= next_blit_ctrl;
    end
  end

  // Two-stage synchronisers on inputs from outside this domain
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      busy_sync1 <= 1'b0;
      busy_sync2 <= 1'b0;
      cfg_sync1 <= 8'h00;
      cfg_sync2 <= 8'h00;
      dest_sync1 <= 3'h0;
      dest_sync2 <= 3'h0;
    end else begin
      busy_sync1 <= ENGINE_BUSY;
      busy_sync2 <= busy_sync1;
      cfg_sync1 <= CFG_REG;
      cfg_sync2 <= cfg_sync1;
      dest_sync1 <= DEST_ADDR_LOW;
      dest_sync2 <= dest_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [31:0] ctl_view;
  wire [31:0] rd_mux;
  assign ctl_view = {busy_sync2, blit_ctrl[30:0]};
  assign rd_mux = hit_src ? mono_src_ctrl : hit_ctl ? ctl_view : 32'h00000000;

  // Read data and acknowledge, one cycle after the request
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      REG_RDATA <= 32'h00000000;
      REG_ACK <= 1'b0;
    end else begin
      REG_RDATA <= REG_RD ? (rd_mux & lane_mask(REG_BE)) : 32'h00000000;
      REG_ACK <= REG_RD | REG_WR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived engine settings
  wire depth_local;
  wire [1:0] depth_sel;
  wire src_mono;
  wire pat_mono;
  wire solid;
  wire src_exp_ded;
  wire [23:0] src_bg_pick;
  wire [23:0] src_fg_pick;
  wire [23:0] src_bg_m;
  wire [23:0] src_fg_m;
  wire [23:0] pat_bg_m;
  wire [23:0] pat_fg_m;
  wire [2:0] align_f;
  assign depth_local = blit_ctrl[blit_cfg_pkg::DEPTH_SEL_BIT];
  assign depth_sel = depth_local ? blit_ctrl[blit_cfg_pkg::DEPTH_LSB +: 2] :
                     cfg_sync2[blit_cfg_pkg::CFG_DEPTH_LSB +: 2];
  assign src_mono = blit_ctrl[blit_cfg_pkg::SRC_MONO_BIT];
  assign pat_mono = blit_ctrl[blit_cfg_pkg::PAT_MONO_BIT];
  assign solid = pat_mono & blit_ctrl[blit_cfg_pkg::SOLID_PAT_BIT];
  assign src_exp_ded = mono_src_ctrl[blit_cfg_pkg::SRC_EXP_SEL_BIT];
  assign src_bg_pick = src_exp_ded ? SRC_BG_COLOR : SHARED_BG_COLOR;
  assign src_fg_pick = src_exp_ded ? SRC_FG_COLOR : SHARED_FG_COLOR;
  assign align_f = mono_src_ctrl[blit_cfg_pkg::ALIGN_LSB +: 3];

  // Source expansion colors, trimmed to depth
  blit_color_expand u_src_expand (
    .depth(depth_sel),
    .bg_in(src_bg_pick),
    .fg_in(src_fg_pick),
    .bg_out(src_bg_m),
    .fg_out(src_fg_m)
  );

  // Pattern expansion colors always use the shared registers
  blit_color_expand u_pat_expand (
    .depth(depth_sel),
    .bg_in(SHARED_BG_COLOR),
    .fg_in(SHARED_FG_COLOR),
    .bg_out(pat_bg_m),
    .fg_out(pat_fg_m)
  );

  // Registered outputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ACTIVE_DEPTH <= 2'h0;
      BYTES_PER_PIXEL <= 2'h1;
      DEPTH_RESERVED <= 1'b0;
      SRC_EXP_BG <= 24'h000000;
      SRC_EXP_FG <= 24'h000000;
      PAT_EXP_BG <= 24'h000000;
      PAT_EXP_FG <= 24'h000000;
      MONO_SRC_ACTIVE <= 1'b0;
      SRC_ALIGN <= 3'h0;
      SRC_ALIGN_RESERVED <= 1'b0;
      SRC_DISCARD <= 6'h00;
      SRC_RCLIP <= 6'h00;
      SRC_LCLIP <= 6'h00;
      PAT_ROW <= 3'h0;
      PAT_HALIGN <= 3'h0;
      PAT_READ_EN <= 1'b1;
      PAT_FORCE_BG <= 1'b0;
    end else begin
      ACTIVE_DEPTH <= depth_sel;
      BYTES_PER_PIXEL <= (depth_sel == blit_cfg_pkg::DEPTH_RSVD) ? 2'h0 : depth_sel + 2'h1;
      DEPTH_RESERVED <= (depth_sel == blit_cfg_pkg::DEPTH_RSVD);
      SRC_EXP_BG <= src_bg_m;
      SRC_EXP_FG <= src_fg_m;
      PAT_EXP_BG <= pat_bg_m;
      PAT_EXP_FG <= solid ? pat_bg_m : pat_fg_m;
      MONO_SRC_ACTIVE <= src_mono;
      SRC_ALIGN <= src_mono ? align_f : 3'h0;
      SRC_ALIGN_RESERVED <= src_mono & ((align_f == blit_cfg_pkg::ALIGN_RSVD0) ||
                            (align_f == blit_cfg_pkg::ALIGN_RSVD6) || (align_f == blit_cfg_pkg::ALIGN_RSVD7));
      SRC_DISCARD <= src_mono ? mono_src_ctrl[blit_cfg_pkg::DISCARD_LSB +: 6] : 6'h00;
      SRC_RCLIP <= src_mono ? mono_src_ctrl[blit_cfg_pkg::RCLIP_LSB +: 6] : 6'h00;
      SRC_LCLIP <= src_mono ? mono_src_ctrl[blit_cfg_pkg::LCLIP_LSB +: 6] : 6'h00;
      PAT_ROW <= blit_ctrl[blit_cfg_pkg::VALIGN_LSB +: 3];
      PAT_HALIGN <= dest_sync2;
      PAT_READ_EN <= ~solid;
      PAT_FORCE_BG <= solid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ctl_write;
    REG_WR && hit_ctl && (REG_BE == 4'hF);
  endsequence

  a_busy_readonly: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_ctl_write |=> (blit_ctrl[31] == 1'b0))
    else $error("busy bit stored by a write");

  a_busy_reads_status: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_RD && hit_ctl && REG_BE[3]) |=> (REG_RDATA[31] == $past(busy_sync2)))
    else $error("busy bit read does not follow status");

  a_src_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_RD && hit_src) |=> ((REG_RDATA & ~blit_cfg_pkg::MONO_SRC_CTRL_MASK) == 32'h00000000))
    else $error("source control reserved bits not zero");

  a_ctl_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_RD && hit_ctl) |=> (REG_RDATA[30:26] == 5'h00))
    else $error("blit control reserved bits not zero");

  a_half_write_keeps: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_WR && hit_src && (REG_BE == 4'h3)) |=> (mono_src_ctrl[31:16] == $past(mono_src_ctrl[31:16])))
    else $error("16-bit write disturbed upper half");

  a_depth_select: assert property (@(posedge CORE_CLK) disable iff (RST)
    ##1 (ACTIVE_DEPTH == ($past(depth_local) ? $past(blit_ctrl[25:24]) : $past(cfg_sync2[5:4]))))
    else $error("depth taken from wrong source");

  a_solid_pattern: assert property (@(posedge CORE_CLK) disable iff (RST)
    (pat_mono && blit_ctrl[19]) |=> (!PAT_READ_EN && PAT_FORCE_BG && (PAT_EXP_FG == PAT_EXP_BG)))
    else $error("solid pattern did not suppress reads");

  a_color_pick: assert property (@(posedge CORE_CLK) disable iff (RST)
    (src_exp_ded && depth_sel == 2'h2) |=> (SRC_EXP_BG == $past(SRC_BG_COLOR)))
    else $error("dedicated source color not used");

  a_clip_mono_only: assert property (@(posedge CORE_CLK) disable iff (RST)
    !src_mono |=> (SRC_LCLIP == 6'h00 && SRC_RCLIP == 6'h00 && SRC_DISCARD == 6'h00))
    else $error("clip fields active for color source");

  // Building blocks: any bus access, and busy arriving at the first synchroniser stage
  sequence s_any_access;
    REG_RD || REG_WR;
  endsequence

  sequence s_busy_rise;
    $rose(busy_sync1);
  endsequence

  a_ack_follows: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_any_access |=> REG_ACK)
    else $error("access not acknowledged");

  a_ack_no_spurious: assert property (@(posedge CORE_CLK) disable iff (RST)
    !(REG_RD || REG_WR) |=> !REG_ACK)
    else $error("acknowledge without access");

  a_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
    !REG_RD |=> (REG_RDATA == 32'h00000000))
    else $error("read data not zero outside a read");

  a_src_readback: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_RD && hit_src && (REG_BE == 4'hF)) |=> (REG_RDATA == $past(mono_src_ctrl)))
    else $error("source control read mismatch");

  a_src_write_lands: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_WR && hit_src && (REG_BE == 4'hF)) |=>
      (mono_src_ctrl == ($past(REG_WDATA) & blit_cfg_pkg::MONO_SRC_CTRL_MASK)))
    else $error("source control write lost");

  a_ctl_write_lands: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_WR && hit_ctl && (REG_BE == 4'hF)) |=>
      (blit_ctrl == ($past(REG_WDATA) & blit_cfg_pkg::BLIT_CTRL_MASK)))
    else $error("blit control write lost");

  a_unmapped_ignored: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_WR && !hit_src && !hit_ctl) |=> ($stable(mono_src_ctrl) && $stable(blit_ctrl)))
    else $error("unmapped write changed a register");

  a_upper_write_keeps: assert property (@(posedge CORE_CLK) disable iff (RST)
    (REG_WR && hit_src && (REG_BE == 4'hC)) |=> (mono_src_ctrl[15:0] == $past(mono_src_ctrl[15:0])))
    else $error("16-bit write disturbed lower half");

  a_busy_reaches_view: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_busy_rise |=> busy_sync2)
    else $error("busy status lost in synchroniser");

  a_bpp_8: assert property (@(posedge CORE_CLK) disable iff (RST)
    (depth_sel == blit_cfg_pkg::DEPTH_8) |=> (BYTES_PER_PIXEL == 2'h1))
    else $error("8 bpp gives wrong byte count");

  a_bpp_16: assert property (@(posedge CORE_CLK) disable iff (RST)
    (depth_sel == blit_cfg_pkg::DEPTH_16) |=> (BYTES_PER_PIXEL == 2'h2))
    else $error("16 bpp gives wrong byte count");

  a_bpp_24: assert property (@(posedge CORE_CLK) disable iff (RST)
    (depth_sel == blit_cfg_pkg::DEPTH_24) |=> (BYTES_PER_PIXEL == 2'h3))
    else $error("24 bpp gives wrong byte count");

  a_depth_reserved: assert property (@(posedge CORE_CLK) disable iff (RST)
    (depth_sel == blit_cfg_pkg::DEPTH_RSVD) |=> (DEPTH_RESERVED && (BYTES_PER_PIXEL == 2'h0)))
    else $error("reserved depth not flagged");

  a_width_8: assert property (@(posedge CORE_CLK) disable iff (RST)
    (depth_sel == blit_cfg_pkg::DEPTH_8) |=> ((SRC_EXP_BG[23:8] == 16'h0000) && (PAT_EXP_FG[23:8] == 16'h0000)))
    else $error("8 bpp expansion color too wide");

  a_shared_pick: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!src_exp_ded && (depth_sel == blit_cfg_pkg::DEPTH_24)) |=>
      ((SRC_EXP_BG == $past(SHARED_BG_COLOR)) && (SRC_EXP_FG == $past(SHARED_FG_COLOR))))
    else $error("shared source colors not used");

  a_align_passes: assert property (@(posedge CORE_CLK) disable iff (RST)
    src_mono |=> (SRC_ALIGN == $past(align_f)))
    else $error("source alignment not passed on");

  a_align_valid: assert property (@(posedge CORE_CLK) disable iff (RST)
    (src_mono && (align_f >= blit_cfg_pkg::ALIGN_BIT) && (align_f <= blit_cfg_pkg::ALIGN_QWORD)) |=>
      !SRC_ALIGN_RESERVED)
    else $error("valid alignment flagged reserved");

  a_discard_passes: assert property (@(posedge CORE_CLK) disable iff (RST)
    src_mono |=> (SRC_DISCARD == $past(mono_src_ctrl[blit_cfg_pkg::DISCARD_LSB +: 6])))
    else $error("initial discard not passed on");

  a_rclip_passes: assert property (@(posedge CORE_CLK) disable iff (RST)
    src_mono |=> (SRC_RCLIP == $past(mono_src_ctrl[blit_cfg_pkg::RCLIP_LSB +: 6])))
    else $error("right clip not passed on");

  a_lclip_passes: assert property (@(posedge CORE_CLK) disable iff (RST)
    src_mono |=> (SRC_LCLIP == $past(mono_src_ctrl[blit_cfg_pkg::LCLIP_LSB +: 6])))
    else $error("left clip not passed on");

  a_pat_row: assert property (@(posedge CORE_CLK) disable iff (RST)
    1'b1 |=> (PAT_ROW == $past(blit_ctrl[blit_cfg_pkg::VALIGN_LSB +: 3])))
    else $error("pattern row not passed on");

  a_pat_halign: assert property (@(posedge CORE_CLK) disable iff (RST)
    1'b1 |=> (PAT_HALIGN == $past(dest_sync2)))
    else $error("horizontal alignment not from destination");

  a_pattern_reads: assert property (@(posedge CORE_CLK) disable iff (RST)
    !solid |=> (PAT_READ_EN && !PAT_FORCE_BG && (PAT_EXP_FG == $past(pat_fg_m))))
    else $error("pattern reads wrongly suppressed");
endmodule : blit_mono_source_and_control

// [verif/blit_mono_source_and_control_tb.sv]
// Self-checking testbench for the block-transfer configuration registers
`timescale 1ns/10ps
module blit_mono_source_and_control_tb;
  localparam logic [23:0] SRC = blit_cfg_pkg::MONO_SRC_CTRL_OFFSET;
  localparam logic [23:0] BLT = blit_cfg_pkg::BLIT_CTRL_OFFSET;
  typedef struct {logic [23:0] addr; logic [3:0] be; logic [31:0] wdata; logic [31:0] rdata;} row_t;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, engine_busy = 1'b0;
  logic [23:0] reg_addr = 24'h000000;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [7:0] cfg_reg = 8'h00;
  logic [2:0] dest_addr_low = 3'h0;
  logic [23:0] sh_bg = 24'hA1B2C3, sh_fg = 24'h1D2E3F, src_bg = 24'h4C5D6E, src_fg = 24'h7A8B9C;
  logic [31:0] reg_rdata, rd;
  logic reg_ack, depth_rsvd, mono_act, align_rsvd, pat_rd_en, pat_force_bg;
  logic [1:0] act_depth, bpp;
  logic [23:0] s_bg, s_fg, p_bg, p_fg, msk;
  logic [2:0] s_align, pat_row, pat_halign;
  logic [5:0] s_disc, s_rclip, s_lclip;
  int fails = 0, cmp_count = 0;
  row_t rows [8];

  blit_mono_source_and_control u_blit_mono_source_and_control (.CORE_CLK(core_clk), .RST(rst),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_BE(reg_be), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .ENGINE_BUSY(engine_busy), .CFG_REG(cfg_reg),
    .DEST_ADDR_LOW(dest_addr_low), .SHARED_BG_COLOR(sh_bg), .SHARED_FG_COLOR(sh_fg),
    .SRC_BG_COLOR(src_bg), .SRC_FG_COLOR(src_fg), .ACTIVE_DEPTH(act_depth), .BYTES_PER_PIXEL(bpp),
    .DEPTH_RESERVED(depth_rsvd), .SRC_EXP_BG(s_bg), .SRC_EXP_FG(s_fg), .PAT_EXP_BG(p_bg),
    .PAT_EXP_FG(p_fg), .MONO_SRC_ACTIVE(mono_act), .SRC_ALIGN(s_align), .SRC_ALIGN_RESERVED(align_rsvd),
    .SRC_DISCARD(s_disc), .SRC_RCLIP(s_rclip), .SRC_LCLIP(s_lclip), .PAT_ROW(pat_row),
    .PAT_HALIGN(pat_halign), .PAT_READ_EN(pat_rd_en), .PAT_FORCE_BG(pat_force_bg));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard
  initial begin
    #1000000;
    fails++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle

  // One strobe cycle; ack and read data are looked at one cycle later
  task bus(input logic wr, input logic [23:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = ~wr;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    check("ack", 32'(reg_ack), 32'h00000001);
    rd = reg_rdata;
  endtask : bus

  task rd_chk(input string what, input logic [23:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hF, 32'h00000000);
    check(what, rd, exp);
  endtask : rd_chk

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rows = '{'{SRC, 4'hF, 32'hFFFFFFFF, 32'h0F3F3F3F}, '{SRC, 4'hF, 32'h0A150C2A, 32'h0A150C2A},
             '{SRC, 4'h3, 32'h0000FFFF, 32'h0A153F3F}, '{SRC, 4'hC, 32'h12340000, 32'h02343F3F},
             '{BLT, 4'hF, 32'hFFFFFFFF, 32'h03FFF7FF}, '{BLT, 4'h3, 32'h00000000, 32'h03FF0000},
             '{BLT, 4'hC, 32'h00000000, 32'h00000000}, '{24'h400014, 4'hF, 32'hFFFFFFFF, 32'h00000000}};
    settle(10);
    rst = 1'b0;
    // Reset state
    check("rdata idle", reg_rdata, 32'h00000000);
    check("bpp reset", 32'(bpp), 32'h00000001);
    check("pat read reset", 32'(pat_rd_en), 32'h00000001);
    rd_chk("src reset", SRC, 32'h00000000);
    rd_chk("blit reset", BLT, 32'h00000000);
    $display("test reset done");
    // Write and read back, masks, byte lanes, unmapped place
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].be, rows[i].wdata);
      rd_chk("readback", rows[i].addr, rows[i].rdata);
    end
    $display("test table done");
    // Busy status is read only
    engine_busy = 1'b1;
    settle(3);
    bus(1'b1, BLT, 4'hF, 32'h00000000);
    rd_chk("busy", BLT, 32'h80000000);
    engine_busy = 1'b0;
    settle(3);
    rd_chk("idle", BLT, 32'h00000000);
    $display("test busy done");
    // Local depth codes, bytes per pixel and expansion width
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, BLT, 4'hF, 32'h00800000 | (32'(i) << 24));
      settle(1);
      msk = (i == 1) ? 24'h00FFFF : ((i == 2) ? 24'hFFFFFF : 24'h0000FF);
      check("depth", 32'(act_depth), 32'(i));
      check("bytes", 32'(bpp), (i == 3) ? 32'h00000000 : 32'(i + 1));
      check("depth rsvd", 32'(depth_rsvd), 32'(i == 3));
      check("pat bg", 32'(p_bg), 32'(sh_bg & msk));
      check("pat fg", 32'(p_fg), 32'(sh_fg & msk));
    end
    // Engine depth follows the display setting in the configuration input
    bus(1'b1, BLT, 4'hF, 32'h01000000);
    cfg_reg = 8'h20;
    settle(4);
    check("cfg depth", 32'(act_depth), 32'h00000002);
    $display("test depth done");
    // Monochrome source fields and color pick
    // Settings are written here while the engine reports idle
    bus(1'b1, BLT, 4'hF, 32'h02801000);
    bus(1'b1, SRC, 4'hF, 32'h0D150C2A);
    settle(1);
    check("mono", 32'(mono_act), 32'h00000001);
    check("align", 32'(s_align), 32'h00000005);
    check("align rsvd", 32'(align_rsvd), 32'h00000000);
    check("discard", 32'(s_disc), 32'h00000015);
    check("rclip", 32'(s_rclip), 32'h0000000C);
    check("lclip", 32'(s_lclip), 32'h0000002A);
    check("src bg", 32'(s_bg), 32'(src_bg));
    check("src fg", 32'(s_fg), 32'(src_fg));
    bus(1'b1, SRC, 4'hF, 32'h06000000);
    settle(1);
    check("align rsvd6", 32'(align_rsvd), 32'h00000001);
    check("shared bg", 32'(s_bg), 32'(sh_bg));
    bus(1'b1, BLT, 4'hF, 32'h02800000);
    settle(1);
    check("color src", 32'(s_align), 32'h00000000);
    $display("test source done");
    // Pattern row, horizontal alignment and solid pattern
    dest_addr_low = 3'h6;
    bus(1'b1, BLT, 4'hF, 32'h02DC0000);
    settle(3);
    check("row", 32'(pat_row), 32'h00000005);
    check("halign", 32'(pat_halign), 32'h00000006);
    check("no read", 32'(pat_rd_en), 32'h00000000);
    check("force bg", 32'(pat_force_bg), 32'h00000001);
    check("solid fg", 32'(p_fg), 32'(sh_bg));
    bus(1'b1, BLT, 4'hF, 32'h02880000);
    settle(1);
    check("color pat", 32'(pat_rd_en), 32'h00000001);
    check("color fg", 32'(p_fg), 32'(sh_fg));
    $display("test pattern done");
    // Reset in mid-run
    bus(1'b1, SRC, 4'hF, 32'h0123ABCD);
    @(negedge core_clk);
    rst = 1'b1;
    settle(2);
    rst = 1'b0;
    check("bpp rst", 32'(bpp), 32'h00000001);
    check("mono rst", 32'(mono_act), 32'h00000000);
    check("pat read rst", 32'(pat_rd_en), 32'h00000001);
    check("ack rst", 32'(reg_ack), 32'h00000000);
    rd_chk("src rst", SRC, 32'h00000000);
    rd_chk("blit rst", BLT, 32'h00000000);
    $display("test second reset done");
    give_verdict();
  end
endmodule : blit_mono_source_and_control_tb
